// File: servo_input_map.svh
`ifndef SERVO_INPUT_MAP_SVH
`define SERVO_INPUT_MAP_SVH

// Register byte offsets.
`define ADDR_CONFIG      4'h0
`define ADDR_STATUS      4'h4
`define ADDR_PROBE_ONE   4'h8
`define ADDR_PROBE_TWO   4'hc

// Configuration word field positions.
`define CFG_STOP_LO      0
`define CFG_STOP_HI      1
`define CFG_DISABLE      2
`define CFG_DOG_POL      3
`define CFG_AUTO_LO      4
`define CFG_AUTO_HI      7
`define CFG_KEEP_DRIVE   8
`define CFG_LOOP_EN      9
`define CFG_PULSE_VAR    10
`define CFG_PULSE_STOP   11
`define CFG_NET_VAR      12
`define CFG_TORQUE_MODE  13
`define CFG_RESET        32'h0000_0000

// Field codes.
`define STOP_DECEL       2'h2
`define AUTO_ON_CODE     4'h4

// Timing.
`define FILTER_NS        1000
`define CLK_NS           40
`define FILTER_CYC       ((`FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define ALM_CLR_MS       50
`define ALM_CLR_CYC      ((`ALM_CLR_MS * 1000000) / `CLK_NS)
`define DECEL_CYC        16'h0100

`endif

// File: servo_input_pkg.sv
package servo_input_pkg;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_DECEL = 2'b10,
		ST_STOP  = 2'b11
	} drive_e;

	typedef struct packed {
		logic forced_stop_two_input;
		logic forced_stop_one_input;
		logic forward_travel_limit;
		logic reverse_travel_limit;
		logic proportional_only_select;
		logic gain_set_select;
		logic gain_set_select_alt;
		logic closed_loop_select;
		logic dog_input;
		logic probe_latch_one;
		logic probe_latch_two;
		logic probe_latch_three;
		logic drive_enable_input;
		logic alarm_clear_input;
		logic external_limit_select;
		logic internal_limit_select;
	} inputs_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic        readdatavalid;
		logic        waitrequest;
	} bus_s;

endpackage

// File: servo_input_device_decode.sv
// Summary of operation
// - Forced stop two open: decelerate, then base off, brake.
// - Closing forced stop two releases the stop.
// - Forced stop one open stops; closing releases.
// - One stop input used; torque net alias.
// - Stop field picks input and interlock timing.
// - Disable ignores inputs; alarm still uses method.
// - Pulse variant uses separate stop disable bit.
// - Travel limits inhibit own direction, servo-lock.
// - Proportional select makes speed loop P only.
// - Gain select picks alternate parameter set.
// - Alternate gain select picks third, has priority.
// - Loop select chooses semi or full closed.
// - Dog polarity field sets detection level.
// - Probe input rising latches motor position.
// - Drive enable powers base; release coasts.
// - Auto field four forces drive enable.
// - Clear held 50 ms clears resettable alarms.
// - Clear without alarm cuts drive unless kept.
// - Internal select overrides with alternate limit.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "servo_input_map.svh"

module servo_input_device_decode (
	// Clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RSTN,
	// Avalon-MM slave
	input  wire logic [3:0]             ADDRESS,
	input  wire logic                   READ,
	input  wire logic                   WRITE,
	input  wire logic [31:0]            WRITEDATA,
	input  wire logic [3:0]             BYTEENABLE,
	output logic      [31:0]            READDATA,
	output logic                        WAITREQUEST,
	// Discrete inputs
	input  wire servo_input_pkg::inputs_s DI,
	// Loop state
	input  wire logic [31:0]            MOTOR_POSITION,
	input  wire logic                   ALARM_ACTIVE,
	input  wire logic                   ALARM_RESETTABLE,
	input  wire logic                   MOTOR_STOPPED,
	// Drive actions
	output logic                        BASE_DRIVE_ON,
	output logic                        DYNAMIC_BRAKE_ON,
	output logic                        DECEL_ACTIVE,
	output logic                        BRAKE_INTERLOCK_OUTPUT,
	output logic                        ALARM_CLEAR_PULSE,
	output logic                        POS_DIR_INHIBIT,
	output logic                        NEG_DIR_INHIBIT,
	output logic                        SERVO_LOCK,
	output logic                        PROPORTIONAL_ONLY,
	output logic      [1:0]             GAIN_SET,
	output logic                        FULL_CLOSED_LOOP,
	output logic                        DOG_DETECTED,
	output logic      [1:0]             LIMIT_SOURCE
);

	localparam int FCYC = `FILTER_CYC;
	localparam int ACYC = `ALM_CLR_CYC;

	typedef struct packed {
		logic [15:0] sync0;
		logic [15:0] sync1;
		logic [15:0] stable;
		logic [15:0][5:0] cnt;
		logic [31:0] cfg;
		logic [31:0] probe1;
		logic [31:0] probe2;
		logic [31:0] probe3;
		logic [2:0]  probe_hit;
		logic [21:0] res_cnt;
		logic        res_done;
		logic [15:0] decel_cnt;
		servo_input_pkg::drive_e st;
		logic        clr_pulse;
		logic [31:0] rdata;
		logic        rvalid;
	} state_s;

	state_s q;
	state_s next_q;
	servo_input_pkg::inputs_s f;

	// Returns a 32-bit word with byte enables applied.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Picks code 2 for the high-priority select, 1 for the low one, else 0.
	function automatic logic [1:0] prio_sel(input logic hi, input logic lo);
		if (hi) begin
			return 2'h2;
		end
		return lo ? 2'h1 : 2'h0;
	endfunction

	logic [1:0] stop_method;
	logic       stop_disable;
	logic       use_two;
	logic       stop_open;
	logic       enable_req;
	logic       decel_mode;
	logic       res_idle_cut;

	assign f = servo_input_pkg::inputs_s'(q.stable);
	assign stop_method = q.cfg[`CFG_STOP_HI:`CFG_STOP_LO];
	// Pulse variant ignores the disable field and uses its own bit.
	assign stop_disable = q.cfg[`CFG_PULSE_VAR] ? q.cfg[`CFG_PULSE_STOP]
		: q.cfg[`CFG_DISABLE];
	// Exactly one stop input is honoured; torque on network variant aliases two to one.
	assign use_two = (stop_method == `STOP_DECEL)
		&& !(q.cfg[`CFG_NET_VAR] && q.cfg[`CFG_TORQUE_MODE]);
	assign stop_open = !stop_disable && (use_two ? !f.forced_stop_two_input
		: !f.forced_stop_one_input);
	assign decel_mode = (stop_method == `STOP_DECEL);
	assign enable_req = (q.cfg[`CFG_AUTO_HI:`CFG_AUTO_LO] == `AUTO_ON_CODE)
		|| f.drive_enable_input;
	assign res_idle_cut = f.alarm_clear_input && !ALARM_ACTIVE
		&& !q.cfg[`CFG_KEEP_DRIVE];

	always_comb begin
		logic [2:0] probe_set;
		probe_set = 3'h0;
		next_q = q;
		next_q.clr_pulse = 1'b0;
		next_q.rvalid = 1'b0;
		// ------------------------------------------------------------
		// Input filtering
		// ------------------------------------------------------------
		next_q.sync0 = DI;
		next_q.sync1 = q.sync0;
		for (int i = 0; i < 16; i++) begin
			if (q.sync1[i] == q.stable[i]) begin
				next_q.cnt[i] = 6'h00;
			end else if (int'(q.cnt[i]) >= FCYC - 1) begin
				next_q.cnt[i] = 6'h00;
				next_q.stable[i] = q.sync1[i];
			end else begin
				next_q.cnt[i] = q.cnt[i] + 6'h01;
			end
		end
		// ------------------------------------------------------------
		// Touch probe latch
		// ------------------------------------------------------------
		if (next_q.stable[6] && !q.stable[6]) begin
			next_q.probe1 = MOTOR_POSITION;
			probe_set[0] = 1'b1;
		end
		if (next_q.stable[5] && !q.stable[5]) begin
			next_q.probe2 = MOTOR_POSITION;
			probe_set[1] = 1'b1;
		end
		if (next_q.stable[4] && !q.stable[4]) begin
			next_q.probe3 = MOTOR_POSITION;
			probe_set[2] = 1'b1;
		end
		// ------------------------------------------------------------
		// Alarm clear timing
		// ------------------------------------------------------------
		if (!f.alarm_clear_input) begin
			next_q.res_cnt = 22'h000000;
			next_q.res_done = 1'b0;
		end else if (!q.res_done) begin
			if (int'(q.res_cnt) >= ACYC - 1) begin
				next_q.res_done = 1'b1;
				next_q.clr_pulse = ALARM_ACTIVE && ALARM_RESETTABLE;
			end else begin
				next_q.res_cnt = q.res_cnt + 22'h000001;
			end
		end
		// ------------------------------------------------------------
		// Drive state
		// ------------------------------------------------------------
		unique case (q.st)
			servo_input_pkg::ST_OFF: begin
				if (enable_req && !stop_open && !ALARM_ACTIVE && !res_idle_cut) begin
					next_q.st = servo_input_pkg::ST_RUN;
				end
			end
			servo_input_pkg::ST_RUN: begin
				if (stop_open || ALARM_ACTIVE) begin
					next_q.decel_cnt = 16'h0000;
					next_q.st = decel_mode ? servo_input_pkg::ST_DECEL
						: servo_input_pkg::ST_STOP;
				end else if (!enable_req || res_idle_cut) begin
					next_q.st = servo_input_pkg::ST_OFF;
				end
			end
			servo_input_pkg::ST_DECEL: begin
				// Deceleration ends on standstill or after a fixed timeout, whichever is first.
				next_q.decel_cnt = q.decel_cnt + 16'h0001;
				if (MOTOR_STOPPED || q.decel_cnt == `DECEL_CYC) begin
					next_q.st = servo_input_pkg::ST_STOP;
				end
			end
			servo_input_pkg::ST_STOP: begin
				if (!stop_open && !ALARM_ACTIVE) begin
					next_q.st = servo_input_pkg::ST_OFF;
				end
			end
		endcase
		// ------------------------------------------------------------
		// Register access
		// ------------------------------------------------------------
		if (WRITE && ADDRESS == `ADDR_CONFIG) begin
			next_q.cfg = merge(q.cfg, WRITEDATA, BYTEENABLE);
		end
		// A held read is answered once; its second cycle only ends the wait.
		if (READ && !q.rvalid) begin
			next_q.rvalid = 1'b1;
			unique case (ADDRESS)
				`ADDR_CONFIG:    next_q.rdata = q.cfg;
				`ADDR_STATUS:    next_q.rdata = {11'h000, q.probe_hit, q.stable, q.st};
				`ADDR_PROBE_ONE: next_q.rdata = q.probe1;
				`ADDR_PROBE_TWO: next_q.rdata = q.probe2;
				default:         next_q.rdata = 32'h0000_0000;
			endcase
			if (ADDRESS == `ADDR_STATUS) begin
				next_q.probe_hit = 3'h0;
			end
		end
		// A probe edge in the cycle of a status read survives the clear.
		next_q.probe_hit = next_q.probe_hit | probe_set;
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			q <= '0;
			q.cfg <= `CFG_RESET;
			// Inputs read as on until the filter has seen the pins, so no probe edge follows reset.
			q.stable <= 16'hffff;
			q.sync0 <= 16'hffff;
			q.sync1 <= 16'hffff;
			q.st <= servo_input_pkg::ST_OFF;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Reads wait one cycle for the registered data; writes never wait.
	assign WAITREQUEST = (READ && !q.rvalid);
	assign READDATA = q.rdata;
	assign BASE_DRIVE_ON = (q.st == servo_input_pkg::ST_RUN)
		|| (q.st == servo_input_pkg::ST_DECEL);
	assign DYNAMIC_BRAKE_ON = (q.st == servo_input_pkg::ST_STOP);
	assign DECEL_ACTIVE = (q.st == servo_input_pkg::ST_DECEL);
	assign BRAKE_INTERLOCK_OUTPUT = (q.st == servo_input_pkg::ST_RUN)
		|| (q.st == servo_input_pkg::ST_DECEL);
	assign ALARM_CLEAR_PULSE = q.clr_pulse;
	assign POS_DIR_INHIBIT = !f.forward_travel_limit;
	assign NEG_DIR_INHIBIT = !f.reverse_travel_limit;
	assign SERVO_LOCK = !f.forward_travel_limit || !f.reverse_travel_limit;
	assign PROPORTIONAL_ONLY = f.proportional_only_select;
	assign GAIN_SET = prio_sel(f.gain_set_select_alt, f.gain_set_select);
	assign FULL_CLOSED_LOOP = q.cfg[`CFG_LOOP_EN] && f.closed_loop_select;
	assign DOG_DETECTED = q.cfg[`CFG_DOG_POL] ? f.dog_input : !f.dog_input;
	assign LIMIT_SOURCE = prio_sel(f.internal_limit_select,
		f.external_limit_select);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_DRIVE_OFF_STOP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && stop_open && !decel_mode) |=> DYNAMIC_BRAKE_ON && !BASE_DRIVE_ON)
		else $error("Forced stop did not brake.");
	AST_STOP_RELEASE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_STOP && !stop_open && !ALARM_ACTIVE) |=> !DYNAMIC_BRAKE_ON)
		else $error("Forced stop not released.");
	AST_GAIN_PRIO: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		f.gain_set_select_alt |-> GAIN_SET == 2'h2)
		else $error("Gain priority wrong.");
	AST_TRAVEL: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!f.forward_travel_limit |-> POS_DIR_INHIBIT && SERVO_LOCK)
		else $error("Forward limit not inhibited.");
	AST_DOG: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!q.cfg[`CFG_DOG_POL] |-> DOG_DETECTED == !f.dog_input)
		else $error("Dog polarity wrong.");
	AST_LIMIT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		f.internal_limit_select |-> LIMIT_SOURCE == 2'h2)
		else $error("Limit source wrong.");
	AST_CLR_SHORT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$rose(f.alarm_clear_input) |-> !ALARM_CLEAR_PULSE [*8])
		else $error("Alarm cleared too soon.");
	AST_PROBE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$rose(q.stable[6]) |-> q.probe_hit[0])
		else $error("Probe not latched.");
	// ------------------------------------------------------------
	// Sequence checks
	// ------------------------------------------------------------
	AST_STOP_TWO_IDLE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && !use_two && !f.forced_stop_two_input && !stop_open
		&& !ALARM_ACTIVE && enable_req && !res_idle_cut) |=> BASE_DRIVE_ON)
		else $error("Unused stop input acted.");
	AST_STOP_ONE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_STOP && !use_two && !stop_disable
		&& f.forced_stop_one_input && !ALARM_ACTIVE) |=> !DYNAMIC_BRAKE_ON)
		else $error("Forced stop one not released.");
	AST_DISABLED: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && stop_disable && !ALARM_ACTIVE && enable_req
		&& !res_idle_cut) |=> BASE_DRIVE_ON)
		else $error("Disabled stop input acted.");
	AST_ALARM_STOP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && ALARM_ACTIVE && !decel_mode)
		|=> DYNAMIC_BRAKE_ON && !BRAKE_INTERLOCK_OUTPUT)
		else $error("Alarm stop kept interlock.");
	AST_PULSE_VAR: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.cfg[`CFG_PULSE_VAR] && q.cfg[`CFG_PULSE_STOP]) |-> !stop_open)
		else $error("Pulse variant stop not disabled.");
	AST_DECEL_ENTRY: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && (stop_open || ALARM_ACTIVE) && decel_mode)
		|=> DECEL_ACTIVE && BRAKE_INTERLOCK_OUTPUT)
		else $error("Deceleration not entered.");
	AST_DECEL_END: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_DECEL && MOTOR_STOPPED)
		|=> DYNAMIC_BRAKE_ON && !BRAKE_INTERLOCK_OUTPUT)
		else $error("Interlock held after deceleration.");
	AST_DECEL_BOUND: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		q.st == servo_input_pkg::ST_DECEL |-> q.decel_cnt <= `DECEL_CYC)
		else $error("Deceleration overran.");
	AST_COAST: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_RUN && !stop_open && !ALARM_ACTIVE && !enable_req)
		|=> !BASE_DRIVE_ON && !DYNAMIC_BRAKE_ON)
		else $error("Drive did not coast.");
	AST_AUTO_ON: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_OFF && q.cfg[`CFG_AUTO_HI:`CFG_AUTO_LO] == `AUTO_ON_CODE
		&& !stop_open && !ALARM_ACTIVE && !res_idle_cut) |=> BASE_DRIVE_ON)
		else $error("Automatic drive enable ignored.");
	AST_CLR_IDLE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(q.st == servo_input_pkg::ST_OFF && res_idle_cut) |=> !BASE_DRIVE_ON)
		else $error("Clear without alarm left drive on.");
	AST_DIR_NEG: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!f.reverse_travel_limit |-> NEG_DIR_INHIBIT && SERVO_LOCK)
		else $error("Reverse limit not inhibited.");
	AST_PROP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		PROPORTIONAL_ONLY == f.proportional_only_select)
		else $error("Proportional select not followed.");
	AST_GAIN_ONE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		(f.gain_set_select && !f.gain_set_select_alt) |-> GAIN_SET == 2'h1)
		else $error("Alternate gain set not chosen.");
	AST_LOOP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!q.cfg[`CFG_LOOP_EN] |-> !FULL_CLOSED_LOOP)
		else $error("Loop switch acted while disabled.");
	AST_LIMIT_EXT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!f.internal_limit_select |-> LIMIT_SOURCE == {1'b0, f.external_limit_select})
		else $error("External limit source wrong.");
	AST_FILTER: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$changed(q.stable[6]) |-> q.stable[6] == $past(q.sync1[6])
		&& q.stable[6] == $past(q.sync1[6], 8))
		else $error("Filter passed a short pulse.");
	AST_PROBE_VALUE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		$rose(q.stable[6]) |-> q.probe1 == $past(MOTOR_POSITION))
		else $error("Probe position wrong.");
	COV_DECEL: cover property (@(posedge REF_CLK) q.st == servo_input_pkg::ST_DECEL);
	COV_STOP: cover property (@(posedge REF_CLK) q.st == servo_input_pkg::ST_STOP);
	COV_CLR: cover property (@(posedge REF_CLK) ALARM_CLEAR_PULSE);
	COV_ALARM: cover property (@(posedge REF_CLK) q.st == servo_input_pkg::ST_STOP && ALARM_ACTIVE);
	COV_PROBE: cover property (@(posedge REF_CLK) q.probe_hit[0]);

endmodule
`default_nettype wire

// File: servo_input_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

module servo_input_ctrl_model (
	// Clock
	input  wire logic                     REF_CLK,
	// Discrete inputs toward the block
	output var  servo_input_pkg::inputs_s DI
);
	// -------------------------------------------------------------
	// Controller side of the discrete inputs
	// -------------------------------------------------------------
	// Set when the controller runs the axis in torque mode.
	logic torque_mode = 1'b0;
	// Last word put on the pins, used to keep alarm clear off a running axis.
	servo_input_pkg::inputs_s last = 16'hf000;

	initial DI = 16'hf000;

	task automatic drive(input servo_input_pkg::inputs_s v);
		servo_input_pkg::inputs_s w;
		w = v;
		if (torque_mode) begin
			w.proportional_only_select = 1'b0;
		end
		if (w.alarm_clear_input && !last.alarm_clear_input && last.drive_enable_input) begin
			w.alarm_clear_input = 1'b0;
		end
		@(posedge REF_CLK);
		DI <= w;
		last = w;
	endtask
endmodule

`default_nettype wire

// File: servo_input_device_decode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module servo_input_device_decode_tb_top;
	logic                     ref_clk    = 1'b0;
	logic                     rstn       = 1'b0;
	logic [3:0]               address    = 4'h0;
	logic                     read       = 1'b0;
	logic                     write      = 1'b0;
	logic [31:0]              writedata  = 32'h0;
	logic [3:0]               byteenable = 4'hf;
	logic [31:0]              motor_pos  = 32'h0;
	logic                     alarm_on   = 1'b0;
	logic                     alarm_res  = 1'b0;
	logic                     stopped    = 1'b0;
	logic [31:0]              readdata;
	logic                     waitrequest;
	servo_input_pkg::inputs_s di;
	servo_input_pkg::inputs_s v;
	logic                     base_on, dbrake, decel, ilock, clr_pulse;
	logic                     pos_inh, neg_inh, slock, prop, full_loop, dog_det;
	logic [1:0]               gain_set, limit_src;
	logic [31:0]              rd;
	int                       n_fail     = 0;
	int                       num_checks = 0;
	int                       cycles     = 0;

	servo_input_ctrl_model i_ctrl (.REF_CLK(ref_clk), .DI(di));

	servo_input_device_decode i_dut (
		.REF_CLK(ref_clk), .RSTN(rstn), .ADDRESS(address), .READ(read), .WRITE(write),
		.WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
		.WAITREQUEST(waitrequest), .DI(di), .MOTOR_POSITION(motor_pos),
		.ALARM_ACTIVE(alarm_on), .ALARM_RESETTABLE(alarm_res), .MOTOR_STOPPED(stopped),
		.BASE_DRIVE_ON(base_on), .DYNAMIC_BRAKE_ON(dbrake), .DECEL_ACTIVE(decel),
		.BRAKE_INTERLOCK_OUTPUT(ilock), .ALARM_CLEAR_PULSE(clr_pulse),
		.POS_DIR_INHIBIT(pos_inh), .NEG_DIR_INHIBIT(neg_inh), .SERVO_LOCK(slock),
		.PROPORTIONAL_ONLY(prop), .GAIN_SET(gain_set), .FULL_CLOSED_LOOP(full_loop),
		.DOG_DETECTED(dog_det), .LIMIT_SOURCE(limit_src));

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	initial forever #20 ref_clk = ~ref_clk;

	task automatic print_verdict();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			print_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address   <= a;
		writedata <= d;
		write     <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		read    <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask

	// Input filter needs 2 sync plus 25 stable cycles before a change shows.
	task automatic apply();
		i_ctrl.drive(v);
		repeat (40) @(posedge ref_clk);
	endtask

	task automatic cfg(input logic [31:0] d);
		bus_write(4'h0, d);
		repeat (4) @(posedge ref_clk);
	endtask

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_regs();
		check("base_after_reset", 32'h0, base_on);
		check("ilock_after_reset", 32'h0, ilock);
		bus_read(4'h0, rd);
		check("cfg_reset", 32'h0, rd);
		cfg(32'h0000_3fff);
		bus_read(4'h0, rd);
		check("cfg_readback", 32'h0000_3fff, rd);
		cfg(32'h0);
	endtask

	task automatic t_stop_one();
		v.drive_enable_input = 1'b1;
		apply();
		check("base_on", 32'h1, base_on);
		check("ilock_run", 32'h1, ilock);
		v.forced_stop_two_input = 1'b0;
		apply();
		check("two_ignored", 32'h1, base_on);
		v.forced_stop_two_input = 1'b1;
		v.forced_stop_one_input = 1'b0;
		apply();
		check("one_base", 32'h0, base_on);
		check("one_brake", 32'h1, dbrake);
		check("one_ilock", 32'h0, ilock);
		v.forced_stop_one_input = 1'b1;
		apply();
		check("one_release", 32'h1, base_on);
	endtask

	task automatic t_stop_two();
		cfg(32'h0000_0002);
		v.forced_stop_two_input = 1'b0;
		apply();
		check("two_decel", 32'h1, decel);
		check("two_ilock_decel", 32'h1, ilock);
		stopped <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("two_base", 32'h0, base_on);
		check("two_ilock", 32'h0, ilock);
		v.forced_stop_two_input = 1'b1;
		apply();
		stopped <= 1'b0;
		check("two_release", 32'h1, base_on);
	endtask

	task automatic t_disable();
		cfg(32'h0000_0004);
		v.forced_stop_one_input = 1'b0;
		apply();
		check("disabled_stop", 32'h1, base_on);
		alarm_on <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("alarm_brake", 32'h1, dbrake);
		check("alarm_ilock", 32'h0, ilock);
		alarm_on <= 1'b0;
		cfg(32'h0000_0404);
		check("pulse_var_stop", 32'h0, base_on);
		v.forced_stop_one_input = 1'b1;
		apply();
		cfg(32'h0);
	endtask

	task automatic t_servo();
		v.drive_enable_input = 1'b0;
		apply();
		check("coast_base", 32'h0, base_on);
		check("coast_brake", 32'h0, dbrake);
		cfg(32'h0000_0040);
		check("auto_on", 32'h1, base_on);
		cfg(32'h0);
		v.drive_enable_input = 1'b1;
		v.alarm_clear_input = 1'b1;
		apply();
		check("clear_no_alarm", 32'h0, base_on);
		check("clear_no_pulse", 32'h0, clr_pulse);
		cfg(32'h0000_0100);
		check("clear_keep", 32'h1, base_on);
		v.alarm_clear_input = 1'b0;
		apply();
		cfg(32'h0);
	endtask

	task automatic t_tables();
		for (int i = 0; i < 4; i++) begin
			v.forward_travel_limit = i[0];
			v.reverse_travel_limit = i[1];
			v.gain_set_select = i[0];
			v.gain_set_select_alt = i[1];
			v.external_limit_select = i[0];
			v.internal_limit_select = i[1];
			v.proportional_only_select = i[0];
			apply();
			check("pos_inhibit", {31'h0, !i[0]}, pos_inh);
			check("neg_inhibit", {31'h0, !i[1]}, neg_inh);
			check("servo_lock", {31'h0, i != 3}, slock);
			check("proportional", {31'h0, i[0]}, prop);
			check("gain_set", i[1] ? 32'h2 : {31'h0, i[0]}, gain_set);
			check("limit_src", i[1] ? 32'h2 : {31'h0, i[0]}, limit_src);
		end
		v = 16'hf008;
		apply();
	endtask

	task automatic t_loop_dog();
		for (int i = 0; i < 6; i++) begin
			cfg(i < 2 ? 32'h0 : (i < 4 ? 32'h0000_0200 : 32'h0000_0208));
			v.closed_loop_select = i[0];
			v.dog_input = i[0];
			apply();
			check("full_loop", {31'h0, i[0] && i >= 2}, full_loop);
			check("dog_det", {31'h0, i[0] == (i >= 4)}, dog_det);
		end
		cfg(32'h0);
	endtask

	task automatic t_probe();
		motor_pos <= 32'h1234_5678;
		v.probe_latch_one = 1'b1;
		apply();
		motor_pos <= 32'h0;
		bus_read(4'h8, rd);
		check("probe_one", 32'h1234_5678, rd);
	endtask

	initial begin
		v = 16'hf000;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_stop_one();
		t_stop_two();
		t_disable();
		t_servo();
		t_tables();
		t_loop_dog();
		t_probe();
		print_verdict();
	end
endmodule

`default_nettype wire
